// *** inc/stc_pkg.sv ***
// Package: register map, control layout and constants of the 16-bit timer
package stc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 16;

	typedef logic [ADDR_W-1:0] stc_addr_t;
	typedef logic [DATA_W-1:0] stc_data_t;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam stc_addr_t REG_CTRL = 8'h00;
	localparam stc_addr_t REG_CNT_LOW = 8'h04;
	localparam stc_addr_t REG_CNT_HIGH = 8'h08;
	localparam stc_addr_t REG_IRQ = 8'h0C;

	// ----------------------------------------------------------------
	// Control register layout
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wide_access_enable;
		logic unused_zero;
		logic prescale_select_hi;
		logic prescale_select_lo;
		logic crystal_osc_enable;
		logic ext_sync_disable;
		logic count_source_select;
		logic count_run;
	} stc_ctrl_s;

	localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] CTRL_WMASK = 8'hBF;
	localparam int CTRL_UNUSED_BIT = 6;

	// Interrupt register bit positions
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_EN_BIT = 1;

	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	// Prescaler terminal counts for 1:1, 1:2, 1:4, 1:8
	localparam int PRESC_W = 3;
	localparam logic [PRESC_W-1:0] PRESC_DIV1 = 3'h0;
	localparam logic [PRESC_W-1:0] PRESC_DIV2 = 3'h1;
	localparam logic [PRESC_W-1:0] PRESC_DIV4 = 3'h3;
	localparam logic [PRESC_W-1:0] PRESC_DIV8 = 3'h7;

	// Oscillator and shared count pins, index of each in pin vectors
	localparam int PIN_OUT = 0;
	localparam int PIN_IN = 1;

endpackage

// *** rtl/stc_sync.sv ***
// Two flip-flop synchroniser for pin inputs
module stc_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// *** rtl/stc_prescale.sv ***
// Count-input prescaler with 1:1, 1:2, 1:4 and 1:8 ratios
module stc_prescale
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [1:0] sel,
	output logic tick_out
);
	logic [PRESC_W-1:0] cnt_q;
	logic [PRESC_W-1:0] term;

	always_comb
	begin
		unique case (sel)
			2'h0: term = PRESC_DIV1;
			2'h1: term = PRESC_DIV2;
			2'h2: term = PRESC_DIV4;
			2'h3: term = PRESC_DIV8;
		endcase
	end

	// A count left above a newly chosen smaller ratio ends at once
	assign tick_out = tick_in && !clear && (cnt_q >= term);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (clear)
			cnt_q <= '0;
		else if (tick_out)
			cnt_q <= '0;
		else if (tick_in)
			cnt_q <= cnt_q + 1'b1;
	end
endmodule

// *** rtl/stc_timer.sv ***
// 16-bit timer/counter with crystal oscillator control and APB registers
//
// Decided for this implementation: the register offsets and register access over APB.
module stc_timer
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire stc_pkg::stc_addr_t paddr,
	input wire stc_pkg::stc_data_t pwdata,
	output stc_pkg::stc_data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_in_pin_i,
	output logic crystal_in_pin_o,
	output logic crystal_in_pin_oe,
	input wire logic crystal_out_pin_i,
	output logic crystal_out_pin_o,
	output logic crystal_out_pin_oe,
	input wire logic [1:0] port_direction,
	input wire logic [1:0] port_out_data,
	output logic [1:0] port_read_data,
	input wire logic [1:0] special_event_trig,
	input wire logic sleep_mode,
	output logic osc_amp_enable,
	output logic overflow_irq
);
	import stc_pkg::*;

	default clocking cb_assert @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic addr_is(input stc_addr_t a, input stc_addr_t r);
		return a == r;
	endfunction

	stc_ctrl_s ctrl_q;
	logic [BYTE_W-1:0] cnt_low_q;
	logic [BYTE_W-1:0] cnt_high_q;
	logic [BYTE_W-1:0] high_buf_q;
	logic flag_q;
	logic irq_en_q;
	stc_data_t prdata_q;
	logic [1:0] port_rd_q;

	logic hit;
	logic setup_rd;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_irq;
	logic cnt_wr;
	logic trig_any;
	logic tick;
	logic wrap;
	logic [CNT_W-1:0] count;

	assign count = {cnt_high_q, cnt_low_q};

	assign hit = addr_is(paddr, REG_CTRL) || addr_is(paddr, REG_CNT_LOW)
		|| addr_is(paddr, REG_CNT_HIGH) || addr_is(paddr, REG_IRQ);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign setup_rd = psel && !penable && !pwrite;
	assign wr_ctrl = psel && penable && pwrite && addr_is(paddr, REG_CTRL);
	assign wr_low = psel && penable && pwrite
		&& addr_is(paddr, REG_CNT_LOW);
	assign wr_high = psel && penable && pwrite
		&& addr_is(paddr, REG_CNT_HIGH);
	assign wr_irq = psel && penable && pwrite && addr_is(paddr, REG_IRQ);
	assign prdata = prdata_q;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= stc_ctrl_s'(CTRL_RESET);
		else if (wr_ctrl)
			ctrl_q <= stc_ctrl_s'(pwdata[BYTE_W-1:0] & CTRL_WMASK);
	end

	// ----------------------------------------------------------------
	// Pins and oscillator
	// ----------------------------------------------------------------
	logic [1:0] pin_s;
	logic src_level;
	logic src_prev_q;
	logic raw_edge;
	logic sync_edge_q;
	logic ext_edge;
	logic presc_in;

	stc_sync #(
		.W(2)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({crystal_in_pin_i, crystal_out_pin_i}),
		.q(pin_s)
	);

	// Amplifier control ignores sleep so the crystal keeps running
	assign osc_amp_enable = ctrl_q.crystal_osc_enable;

	// Port direction is overridden while the oscillator owns the pins
	assign crystal_out_pin_o = port_out_data[PIN_OUT];
	assign crystal_in_pin_o = port_out_data[PIN_IN];
	assign crystal_out_pin_oe = !ctrl_q.crystal_osc_enable
		&& !port_direction[PIN_OUT];
	assign crystal_in_pin_oe = !ctrl_q.crystal_osc_enable
		&& !port_direction[PIN_IN];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_rd_q <= '0;
		else if (ctrl_q.crystal_osc_enable)
			port_rd_q <= '0;
		else
			port_rd_q <= pin_s;
	end
	assign port_read_data = port_rd_q;

	// ----------------------------------------------------------------
	// Count source selection
	// ----------------------------------------------------------------
	// Oscillator input pin when enabled, otherwise the external clock pin
	assign src_level = ctrl_q.crystal_osc_enable
		? pin_s[PIN_IN] : pin_s[PIN_OUT];
	assign raw_edge = src_level && !src_prev_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_prev_q <= 1'b0;
			sync_edge_q <= 1'b0;
		end
		else
		begin
			src_prev_q <= src_level;
			sync_edge_q <= raw_edge;
		end
	end

	// Synchronised path adds a phase-alignment stage; async takes the edge
	assign ext_edge = ctrl_q.ext_sync_disable ? raw_edge : sync_edge_q;

	// Sync counting halts with the core clock in sleep, async keeps going
	always_comb
	begin
		if (ctrl_q.count_source_select)
			presc_in = ext_edge && (ctrl_q.ext_sync_disable
				|| !sleep_mode);
		else
			presc_in = !sleep_mode;
	end

	stc_prescale u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(presc_in && ctrl_q.count_run),
		.clear(wr_low),
		.sel({ctrl_q.prescale_select_hi, ctrl_q.prescale_select_lo}),
		.tick_out(tick)
	);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	assign cnt_wr = wr_low || (wr_high && !ctrl_q.wide_access_enable);
	assign trig_any = |special_event_trig;
	assign wrap = tick && !cnt_wr && !trig_any && (count == CNT_MAX);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_low_q <= BYTE_ZERO;
			cnt_high_q <= BYTE_ZERO;
		end
		else if (wr_low)
		begin
			cnt_low_q <= pwdata[BYTE_W-1:0];
			if (ctrl_q.wide_access_enable)
				cnt_high_q <= high_buf_q;
		end
		else if (wr_high && !ctrl_q.wide_access_enable)
			cnt_high_q <= pwdata[BYTE_W-1:0];
		else if (trig_any)
			{cnt_high_q, cnt_low_q} <= CNT_ZERO;
		else if (tick)
			{cnt_high_q, cnt_low_q} <= count + 1'b1;
	end

	// High byte buffer for wide access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			high_buf_q <= BYTE_ZERO;
		else if (setup_rd && addr_is(paddr, REG_CNT_LOW)
			&& ctrl_q.wide_access_enable)
			high_buf_q <= cnt_high_q;
		else if (wr_high && ctrl_q.wide_access_enable)
			high_buf_q <= pwdata[BYTE_W-1:0];
	end

	// ----------------------------------------------------------------
	// Overflow flag and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= 1'b0;
		else if (wrap)
			flag_q <= 1'b1;
		else if (wr_irq && !pwdata[IRQ_FLAG_BIT])
			flag_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_q <= 1'b0;
		else if (wr_irq)
			irq_en_q <= pwdata[IRQ_EN_BIT];
	end

	assign overflow_irq = flag_q && irq_en_q;

	// ----------------------------------------------------------------
	// Read data, sampled in the setup cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (setup_rd)
		begin
			prdata_q <= '0;
			if (addr_is(paddr, REG_CTRL))
				prdata_q[BYTE_W-1:0] <= ctrl_q;
			else if (addr_is(paddr, REG_CNT_LOW))
				prdata_q[BYTE_W-1:0] <= cnt_low_q;
			else if (addr_is(paddr, REG_CNT_HIGH))
				prdata_q[BYTE_W-1:0] <= ctrl_q.wide_access_enable
					? high_buf_q : cnt_high_q;
			else if (addr_is(paddr, REG_IRQ))
			begin
				prdata_q[IRQ_FLAG_BIT] <= flag_q;
				prdata_q[IRQ_EN_BIT] <= irq_en_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ctrl_bit_unused: assert property (
		ctrl_q[CTRL_UNUSED_BIT] == 1'b0)
		else $error("Unused control bit is set");

	a_wrap_sets_flag: assert property (
		wrap |=> flag_q && count == CNT_ZERO)
		else $error("Wrap did not set flag and zero count");

	a_irq_needs_enable: assert property (
		wrap && irq_en_q && !wr_irq |=> overflow_irq)
		else $error("Enabled overflow raised no interrupt");

	a_flag_sticky: assert property (
		flag_q && !wr_irq |=> flag_q)
		else $error("Flag dropped without software clear");

	a_trig_clears: assert property (
		trig_any && !cnt_wr |=> count == CNT_ZERO)
		else $error("Trigger did not clear the count");

	a_write_wins: assert property (
		wr_low && trig_any |=> cnt_low_q == $past(pwdata[BYTE_W-1:0]))
		else $error("Trigger overrode a counter write");

	a_run_freeze: assert property (
		!ctrl_q.count_run && !cnt_wr && !trig_any |=> $stable(count))
		else $error("Counter moved while stopped");

	a_timer_step: assert property (
		ctrl_q.count_run && !ctrl_q.count_source_select && !sleep_mode
		&& !ctrl_q.prescale_select_hi && !ctrl_q.prescale_select_lo
		&& !cnt_wr && !trig_any
		|=> count == $past(count) + 1'b1)
		else $error("Timer did not advance each cycle");

	a_osc_pins_input: assert property (
		ctrl_q.crystal_osc_enable && $past(ctrl_q.crystal_osc_enable)
		|-> !crystal_in_pin_oe && !crystal_out_pin_oe
		&& port_read_data == 2'b00)
		else $error("Oscillator pins not forced to input");

	a_wide_buffer: assert property (
		setup_rd && addr_is(paddr, REG_CNT_LOW)
		&& ctrl_q.wide_access_enable
		|=> high_buf_q == $past(cnt_high_q))
		else $error("Low read did not latch the high byte");
endmodule

// *** sim/stc_clk_src.sv ***
// Behavioural external count clock source for the timer pins
module stc_clk_src #(
	parameter int HALF = 3
) (
	input wire logic pclk,
	input wire logic start,
	input wire logic [3:0] n_req,
	output logic lvl,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;

	int left = 0;
	int div = 0;

	initial lvl = 1'b0;
	assign busy = (left != 0);

	// ----------------------------------------------------------------
	// Burst of n_req periods, clock stands still low between bursts
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (start)
		begin
			left <= 2 * int'(n_req);
			div <= 0;
		end
		else if (left != 0)
		begin
			div <= (div == HALF - 1) ? 0 : div + 1;
			if (div == HALF - 1)
			begin
				lvl <= ~lvl;
				left <= left - 1;
			end
		end
	end
endmodule

// *** sim/stc_timer_tb.sv ***
// Self-checking testbench of the 16-bit timer/counter
module stc_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import stc_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, sleep_mode;
	stc_addr_t paddr;
	stc_data_t pwdata, prdata, rd;
	logic pready, pslverr, err, in_o, in_oe, out_o, out_oe;
	logic src, start, busy, osc_amp, irq, sy, in_w, out_w;
	logic [1:0] port_direction, port_out_data, port_read_data, trig;
	logic [3:0] n_req, nv;
	logic [7:0] ctl;
	logic [31:0] seed = 32'h935a_beca;
	logic [31:0] r;
	logic [7:0] ext_cfg [3] = '{8'h03, 8'h07, 8'h0F};
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int k, m;

	assign in_w = in_oe ? in_o : src;
	assign out_w = out_oe ? out_o : src;

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	stc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .crystal_in_pin_i(in_w),
		.crystal_in_pin_o(in_o), .crystal_in_pin_oe(in_oe),
		.crystal_out_pin_i(out_w), .crystal_out_pin_o(out_o),
		.crystal_out_pin_oe(out_oe), .port_direction(port_direction),
		.port_out_data(port_out_data), .port_read_data(port_read_data),
		.special_event_trig(trig), .sleep_mode(sleep_mode),
		.osc_amp_enable(osc_amp), .overflow_irq(irq));

	stc_clk_src u_src (.pclk(pclk), .start(start), .n_req(n_req),
		.lvl(src), .busy(busy));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] exp_cnt(input int s, input int gap);
		return 8'((gap + 3) / (1 << s));
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] got);
		checks_done++;
		if (got !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, got);
		end
	endtask

	task automatic apb(input logic wr_n, input stc_addr_t a,
		input logic [7:0] d, input logic [1:0] tg);
		psel <= 1'b1;
		pwrite <= wr_n;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		trig <= tg;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		trig <= 2'h0;
		@(posedge pclk);
	endtask

	task automatic wr(input stc_addr_t a, input logic [7:0] d);
		apb(1'b1, a, d, 2'h0);
	endtask

	task automatic rdchk(input string nm, input stc_addr_t a,
		input logic [7:0] e);
		apb(1'b0, a, 8'h00, 2'h0);
		chk(nm, {24'h00_0000, e}, rd);
	endtask

	task automatic summarize();
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		sleep_mode = 1'b0;
		trig = 2'h0;
		port_direction = 2'b11;
		port_out_data = 2'b01;
		start = 1'b0;
		n_req = 4'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk("ctrl", REG_CTRL, 8'h00);
		rdchk("irq", REG_IRQ, 8'h00);
		rdchk("low", REG_CNT_LOW, 8'h00);
		wr(REG_CTRL, 8'hFE);
		rdchk("ctrl", REG_CTRL, 8'hBE);
		chk("osc", 32'h1, {31'h0, osc_amp});
		chk("oe", 32'h0, {30'h0, in_oe, out_oe});
		chk("pins", 32'h0, {30'h0, port_read_data});
		wr(REG_CTRL, 8'h00);
		port_direction <= 2'b00;
		@(posedge pclk);
		chk("oe", 32'h3, {30'h0, in_oe, out_oe});
		chk("osc", 32'h0, {31'h0, osc_amp});
		// Driven pins reach the read path again once the oscillator is off
		repeat (3) @(posedge pclk);
		chk("pins", 32'h1, {30'h0, port_read_data});
		port_direction <= 2'b11;
		apb(1'b0, 8'h10, 8'h00, 2'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmap", 32'h0, rd);
		// Timer mode, every prescale code, random run length
		for (int s = 0; s < 4; s++)
		begin
			r = nxt();
			k = int'(r[7:0]) % 5;
			sy = r[8];
			m = (1 << s) * (k + 3) - 3;
			ctl = {2'b00, 2'(s), 1'b0, sy, 2'b00};
			wr(REG_CTRL, ctl);
			wr(REG_CNT_HIGH, 8'h00);
			wr(REG_CNT_LOW, 8'h00);
			wr(REG_CTRL, ctl | 8'h01);
			repeat (m) @(posedge pclk);
			wr(REG_CTRL, 8'h00);
			rdchk("tmr", REG_CNT_LOW, exp_cnt(s, m));
			rdchk("tmr", REG_CNT_LOW, exp_cnt(s, m));
		end
		// Overflow, sticky flag and masking
		wr(REG_IRQ, 8'h02);
		wr(REG_CNT_HIGH, 8'hFF);
		wr(REG_CNT_LOW, 8'hFE);
		wr(REG_CTRL, 8'h01);
		wr(REG_CTRL, 8'h00);
		rdchk("wrap", REG_CNT_LOW, 8'h01);
		rdchk("wrap", REG_CNT_HIGH, 8'h00);
		rdchk("flag", REG_IRQ, 8'h03);
		chk("irq", 32'h1, {31'h0, irq});
		wr(REG_IRQ, 8'h01);
		chk("irq", 32'h0, {31'h0, irq});
		rdchk("flag", REG_IRQ, 8'h01);
		wr(REG_IRQ, 8'h00);
		rdchk("flag", REG_IRQ, 8'h00);
		// Wide access through the high byte buffer
		r = nxt();
		wr(REG_CTRL, 8'h80);
		wr(REG_CNT_HIGH, r[7:0]);
		wr(REG_CNT_LOW, r[15:8]);
		wr(REG_CNT_HIGH, ~r[7:0]);
		rdchk("wlow", REG_CNT_LOW, r[15:8]);
		rdchk("whigh", REG_CNT_HIGH, r[7:0]);
		wr(REG_CTRL, 8'h00);
		rdchk("nhigh", REG_CNT_HIGH, r[7:0]);
		// Special event trigger from each compare unit
		for (int t = 0; t < 2; t++)
		begin
			wr(REG_CNT_LOW, 8'h77);
			trig <= 2'(1 << t);
			@(posedge pclk);
			trig <= 2'h0;
			@(posedge pclk);
			rdchk("trig", REG_CNT_LOW, 8'h00);
			apb(1'b1, REG_CNT_LOW, 8'h5A, 2'(1 << t));
			rdchk("trwr", REG_CNT_LOW, 8'h5A);
		end
		// External source: sync, async, oscillator in sleep
		for (int c = 0; c < 3; c++)
		begin
			wr(REG_CNT_HIGH, 8'h00);
			wr(REG_CNT_LOW, 8'h00);
			wr(REG_CTRL, ext_cfg[c]);
			if (c == 2)
				repeat (20) @(posedge pclk);
			sleep_mode <= (c == 2);
			r = nxt();
			nv = r[3:0] | 4'h1;
			n_req <= nv;
			start <= 1'b1;
			@(posedge pclk);
			start <= 1'b0;
			@(posedge pclk);
			while (busy === 1'b1)
				@(posedge pclk);
			repeat (8) @(posedge pclk);
			wr(REG_CTRL, 8'h00);
			sleep_mode <= 1'b0;
			rdchk("ext", REG_CNT_LOW, {4'h0, nv});
		end
		// Reset with the oscillator on and the counter stopped returns control and interrupt state to zero
		wr(REG_IRQ, 8'h02);
		wr(REG_CTRL, 8'h8C);
		chk("osc", 32'h1, {31'h0, osc_amp});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rstosc", 32'h0, {31'h0, osc_amp});
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk("ctrl", REG_CTRL, 8'h00);
		rdchk("irq", REG_IRQ, 8'h00);
		summarize();
	end
endmodule
